//--- verilog/sram_pkg.sv
// Purpose: shared constants and carriers for the burst-of-two DDR SRAM core
// Assumes: one REF_CLK cycle stands for one half cycle of the memory clock pair
// Notes: widths cover the widest organisation; narrower builds mask the upper lanes
package sram_pkg;
    // ==========================================================
    // geometry
    localparam int ADDR_W = 21;
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int LANES_X18 = 2;
    localparam int MEM_ADDR_W = 20;
    localparam int FIFO_DEPTH = 8;
    // ==========================================================
    // timing, in half cycles after the accepting true edge
    localparam logic [2:0] LAT_NORMAL = 3'h5;
    localparam logic [2:0] LAT_LEGACY = 3'h2;
    localparam int PIPE_LEN = 5;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_SECOND = 2'h1;
    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] RD_DATA_RESET = 36'h0;
    localparam logic [LANES-1:0] LANES_IDLE = 4'hF;

    typedef enum logic {PH_TRUE, PH_COMP} phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_n;
    } wbeat_t;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic dll_off_n;
        logic [ADDR_W-1:0] rd_addr;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_n;
    } pins_t;
endpackage

//--- verilog/beat_fifo.sv
// Purpose: write beat buffer between the input port and the array
// Assumes: DEPTH is a power of two
// Notes: the snoop outputs list entries oldest first for read coherency
`timescale 1ns/1ps
module beat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [DEPTH*WIDTH-1:0] snoop_data,
    output logic [DEPTH-1:0] snoop_valid
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign in_ready = count != DEPTH[PW:0];
    assign out_valid = count != '0;
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            snoop_data[i*WIDTH +: WIDTH] = mem[rptr + i[PW-1:0]];
            snoop_valid[i] = i < int'(count);
        end
    end
endmodule

//--- verilog/burst2_ddr_sram_cmd_timing.sv
// Purpose: command decode, beat timing and byte masking of a burst-of-two DDR SRAM
// Assumes: REF_CLK runs at twice the memory clock; even cycles are true edges
// Notes: every pin passes two flops first, so all timing counts from the synced sample
// Summary of operation
// [R1] controller drains all reads and writes before stopping clocks; state then holds
// [R2] read select low at true edge; beats at t+2.5 and t+3.0; else high-Z
// [R3] write select low at true edge; data beats at t and t+0.5
// [R4] operations start every second true edge; consecutive same-kind request is dropped; a read and a write still start at consecutive true edges
// [R5] read and write together after an idle cycle: read done, write dropped
// [R6] every operation is exactly two beats, counted by a two-bit burst counter; only writes use one (wr_beat), reads take two rd_sr taps
// [R7] x18: lane enables gate bits 0-8 and 9-17; both high aborts the beat
// [R8] x36: four lane enables gate 9-bit lanes; all high aborts the beat
// [R9] controller gives lane enables with each beat, write select at true edge
// [R10] second beat uses the command address plus one
// [R11] write select high at true edge stores nothing
// [R12] read valid flag rises half cycle before first beat, falls before last
// [R13] dll bypass low selects one cycle read latency
// [R14] reads of addresses being written return the new data
`timescale 1ns/1ps
module burst2_ddr_sram_cmd_timing #(
    parameter bit ORG_X36 = 1'b1,
    parameter int MEM_ADDR_W = sram_pkg::MEM_ADDR_W,
    parameter int FIFO_DEPTH = sram_pkg::FIFO_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic READ_SEL_N,
    input wire logic WRITE_SEL_N,
    input wire logic DLL_OFF_N,
    input wire logic [sram_pkg::ADDR_W-1:0] RD_ADDR,
    input wire logic [sram_pkg::ADDR_W-1:0] WR_ADDR,
    input wire logic [sram_pkg::DATA_W-1:0] WR_DATA,
    input wire logic BYTE_LANE0_WRITE_N,
    input wire logic BYTE_LANE1_WRITE_N,
    input wire logic BYTE_LANE2_WRITE_N,
    input wire logic BYTE_LANE3_WRITE_N,
    output logic [sram_pkg::DATA_W-1:0] RD_DATA,
    output logic RD_DATA_OE_N,
    output logic READ_VALID_FLAG,
    output logic TRUE_EDGE,
    output logic WR_READY
);
    localparam int BW = $bits(sram_pkg::wbeat_t);

    // ==========================================================
    // helpers
    function automatic logic [sram_pkg::LANES-1:0] org_lanes(
        input logic [sram_pkg::LANES-1:0] lane_n
    );
        logic [sram_pkg::LANES-1:0] res;
        res = lane_n;
        if (!ORG_X36) begin
            res[sram_pkg::LANES-1:sram_pkg::LANES_X18] = '1;
        end
        return res;
    endfunction

    function automatic logic [sram_pkg::DATA_W-1:0] lane_merge(
        input logic [sram_pkg::DATA_W-1:0] old_word,
        input sram_pkg::wbeat_t beat
    );
        logic [sram_pkg::DATA_W-1:0] res;
        res = old_word;
        for (int l = 0; l < sram_pkg::LANES; l++) begin
            if (!beat.lane_n[l]) begin
                res[l*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
                    beat.data[l*sram_pkg::LANE_W +: sram_pkg::LANE_W];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // pin synchronisers
    sram_pkg::pins_t pin_raw;
    sram_pkg::pins_t pin_meta;
    sram_pkg::pins_t pin;

    always_comb begin
        pin_raw.rd_n = READ_SEL_N;
        pin_raw.wr_n = WRITE_SEL_N;
        pin_raw.dll_off_n = DLL_OFF_N;
        pin_raw.rd_addr = RD_ADDR;
        pin_raw.wr_addr = WR_ADDR;
        pin_raw.data = WR_DATA;
        pin_raw.lane_n = {BYTE_LANE3_WRITE_N, BYTE_LANE2_WRITE_N,
                          BYTE_LANE1_WRITE_N, BYTE_LANE0_WRITE_N};
    end

    always_ff @(posedge REF_CLK) begin
        pin_meta <= pin_raw;
        pin <= pin_meta;
    end

    // ==========================================================
    // clock phase: true and complement edges alternate
    sram_pkg::phase_t phase;
    logic k_edge;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            phase <= sram_pkg::PH_TRUE;
        end else begin
            phase <= (phase == sram_pkg::PH_TRUE) ? sram_pkg::PH_COMP : sram_pkg::PH_TRUE;
        end
    end

    assign k_edge = phase == sram_pkg::PH_TRUE;
    assign TRUE_EDGE = k_edge;

    // ==========================================================
    // command decode
    logic rd_prev;
    logic wr_prev;
    logic rd_go;
    logic wr_go;

    assign rd_go = k_edge && !pin.rd_n && !rd_prev; // [R2] [R4]
    // a write alone, or beside a read when the last true edge took a read
    assign wr_go = k_edge && !pin.wr_n && !wr_prev // [R3] [R4] [R11]
        && !(rd_go && !rd_prev && !wr_prev); // [R5]

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end else if (k_edge) begin
            rd_prev <= rd_go;
            wr_prev <= wr_go;
        end
    end

    // ==========================================================
    // write beats into the buffer
    logic [1:0] wr_beat;
    logic [sram_pkg::ADDR_W-1:0] wr_base;
    logic wr_active;
    sram_pkg::wbeat_t in_beat;
    logic in_valid;

    assign wr_active = wr_beat == sram_pkg::BEAT_SECOND;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            wr_beat <= sram_pkg::BEAT_FIRST;
        end else if (wr_go) begin
            wr_beat <= sram_pkg::BEAT_SECOND; // [R6]
        end else begin
            wr_beat <= sram_pkg::BEAT_FIRST;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (wr_go) begin
            wr_base <= pin.wr_addr;
        end
    end

    always_comb begin
        in_beat.addr = wr_go ? pin.wr_addr : wr_base + {{(sram_pkg::ADDR_W-2){1'b0}}, wr_beat}; // [R10]
        in_beat.data = pin.data; // [R3]
        in_beat.lane_n = org_lanes(pin.lane_n); // [R7] [R8] [R9]
        // all lanes high aborts the beat
        in_valid = (wr_go || wr_active) && !(&in_beat.lane_n); // [R7] [R8]
    end

    // ==========================================================
    // buffer and array
    logic fifo_out_valid;
    logic fifo_pop;
    sram_pkg::wbeat_t drain;
    logic [FIFO_DEPTH*BW-1:0] snoop_data;
    logic [FIFO_DEPTH-1:0] snoop_valid;
    logic fetch;
    logic [sram_pkg::DATA_W-1:0] mem [2**MEM_ADDR_W];

    beat_fifo #(.WIDTH(BW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst(SRST),
        .in_valid(in_valid),
        .in_ready(WR_READY),
        .in_data(in_beat),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(drain),
        .snoop_data(snoop_data),
        .snoop_valid(snoop_valid)
    );

    // single array port: a read fetch holds off the drain
    assign fifo_pop = fifo_out_valid && !fetch;

    always_ff @(posedge REF_CLK) begin
        if (fifo_pop) begin
            mem[drain.addr[MEM_ADDR_W-1:0]] <= lane_merge(mem[drain.addr[MEM_ADDR_W-1:0]], drain);
        end
    end

    // ==========================================================
    // read pipeline
    localparam int PIPE_LEN_W = sram_pkg::PIPE_LEN;
    logic [PIPE_LEN_W-1:0] rd_sr;
    logic [sram_pkg::ADDR_W-1:0] rd_addr_sr [sram_pkg::PIPE_LEN];
    logic [2:0] lat;
    logic fetch0;
    logic fetch1;
    logic flag_next;
    logic [sram_pkg::ADDR_W-1:0] fetch_addr;
    logic [sram_pkg::DATA_W-1:0] fetch_word;
    sram_pkg::wbeat_t snoop_beat;

    assign lat = pin.dll_off_n ? sram_pkg::LAT_NORMAL : sram_pkg::LAT_LEGACY; // [R13]

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rd_sr <= '0;
        end else begin
            rd_sr <= {rd_sr[PIPE_LEN_W-2:0], rd_go};
        end
    end

    always_ff @(posedge REF_CLK) begin
        rd_addr_sr[0] <= pin.rd_addr;
        for (int i = 1; i < sram_pkg::PIPE_LEN; i++) begin
            rd_addr_sr[i] <= rd_addr_sr[i-1];
        end
    end

    always_comb begin
        fetch0 = rd_sr[lat - 3'h2]; // [R2]
        fetch1 = rd_sr[lat - 3'h1]; // [R2] [R6]
        fetch = fetch0 || fetch1;
        flag_next = (lat > 3'h2) ? rd_sr[lat - 3'h3] : rd_go; // [R12]
        fetch_addr = fetch0 ? rd_addr_sr[lat - 3'h2]
            : rd_addr_sr[lat - 3'h1] + {{(sram_pkg::ADDR_W-1){1'b0}}, 1'b1}; // [R10]
        fetch_word = mem[fetch_addr[MEM_ADDR_W-1:0]];
        // newest pending write wins, oldest applied first
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            snoop_beat = snoop_data[i*BW +: BW];
            if (snoop_valid[i] && snoop_beat.addr[MEM_ADDR_W-1:0] == fetch_addr[MEM_ADDR_W-1:0]) begin
                fetch_word = lane_merge(fetch_word, snoop_beat); // [R14]
            end
        end
        snoop_beat = in_beat;
        if (in_valid && in_beat.addr[MEM_ADDR_W-1:0] == fetch_addr[MEM_ADDR_W-1:0]) begin
            fetch_word = lane_merge(fetch_word, in_beat); // [R14]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            RD_DATA <= sram_pkg::RD_DATA_RESET;
            RD_DATA_OE_N <= 1'b1;
            READ_VALID_FLAG <= 1'b0;
        end else begin
            if (fetch) begin
                RD_DATA <= fetch_word;
            end
            RD_DATA_OE_N <= !fetch; // [R2]
            READ_VALID_FLAG <= flag_next; // [R12]
        end
    end
endmodule

//--- test/sram_checker.sv
// Purpose: port assertions for the sram core
// Assumes: one REF_CLK cycle is half a memory cycle
// Notes: latency mode is not seen here
`timescale 1ns/1ps
module sram_checker (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic READ_SEL_N,
    input wire logic [sram_pkg::DATA_W-1:0] RD_DATA,
    input wire logic RD_DATA_OE_N,
    input wire logic READ_VALID_FLAG,
    input wire logic TRUE_EDGE,
    input wire logic WR_READY
);
    // ====================
    // read history
    logic [7:0] hist;
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            hist <= 8'h00;
        end else begin
            hist <= {hist[6:0], !READ_SEL_N};
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence beats_s;
        !RD_DATA_OE_N [*2] ##1 RD_DATA_OE_N;
    endsequence
    flag_pulse_a: assert property (READ_VALID_FLAG |=> !READ_VALID_FLAG)
        else $error("flag too long");
    flag_beats_a: assert property (READ_VALID_FLAG |=> beats_s)
        else $error("beats do not follow flag");
    flag_cause_a: assert property (READ_VALID_FLAG |-> (|hist))
        else $error("flag without read");
    oe_cause_a: assert property ($fell(RD_DATA_OE_N) |-> $past(READ_VALID_FLAG))
        else $error("output without flag");
    burst_len_a: assert property (!RD_DATA_OE_N [*2] |=> RD_DATA_OE_N)
        else $error("burst longer than two");
    read_gap_a: assert property (READ_VALID_FLAG |=> !READ_VALID_FLAG [*3])
        else $error("reads too close");
    phase_turn_a: assert property (!$past(SRST) |-> TRUE_EDGE != $past(TRUE_EDGE))
        else $error("phase did not alternate");
    reset_out_a: assert property ($fell(SRST) |-> TRUE_EDGE && RD_DATA_OE_N
        && !READ_VALID_FLAG && WR_READY && RD_DATA == sram_pkg::RD_DATA_RESET)
        else $error("bad state after reset");
endmodule
bind burst2_ddr_sram_cmd_timing sram_checker u_chk (.REF_CLK(REF_CLK), .SRST(SRST),
    .READ_SEL_N(READ_SEL_N), .RD_DATA(RD_DATA), .RD_DATA_OE_N(RD_DATA_OE_N),
    .READ_VALID_FLAG(READ_VALID_FLAG), .TRUE_EDGE(TRUE_EDGE), .WR_READY(WR_READY));

//--- test/ctrl_model.sv
// Purpose: memory controller driving commands and beats
// Assumes: commands go out at falling edges
// Notes: released data lines toggle every cycle
`timescale 1ns/1ps
module ctrl_model (
    input wire logic clk,
    input wire logic true_edge,
    output logic rd_n,
    output logic wr_n,
    output logic [20:0] ra,
    output logic [20:0] wa,
    output logic [35:0] d,
    output logic [3:0] lane_n
);
    // ====================
    // drivers
    initial begin
        {rd_n, wr_n, ra, wa, d, lane_n} = {2'b11, 78'h0, 4'hF};
    end
    // clock never stops with work pending
    task automatic rest();
        @(negedge clk);
        {d, lane_n} = {~d, 4'hF};
    endtask
    task automatic cmd(input logic r, w, input logic [20:0] a, b,
        input logic [35:0] d0, d1, input logic [3:0] l0, l1);
        @(negedge clk);
        if (true_edge !== 1'b1) begin
            {d, lane_n} = {~d, 4'hF};
            @(negedge clk);
        end
        {rd_n, wr_n, ra, wa, d, lane_n} = {r, w, a, b, d0, l0};
        @(negedge clk);
        {rd_n, wr_n, d, lane_n} = {2'b11, d1, l1};
    endtask
endmodule

//--- test/testbench.sv
// Purpose: self-checking bench for the sram core
// Assumes: x36 and x18 builds with six address bits
// Notes: a reference array predicts both read beats
`timescale 1ns/1ps
module testbench;
    logic clk, rst, dn, rn, wn, oe_n, flag, te, wrdy;
    logic [20:0] ra, wa;
    logic [35:0] d, q;
    logic [35:0] q18;
    logic [35:0] mem18 [64];
    logic [3:0] ln;
    logic [35:0] mem [64];
    int n_fail, n_tests, lat, n0, a;
    ctrl_model P (.clk(clk), .true_edge(te), .rd_n(rn), .wr_n(wn), .ra(ra), .wa(wa),
        .d(d), .lane_n(ln));
    burst2_ddr_sram_cmd_timing #(.ORG_X36(1'b1), .MEM_ADDR_W(6), .FIFO_DEPTH(8)) DUT (
        .REF_CLK(clk), .SRST(rst), .READ_SEL_N(rn), .WRITE_SEL_N(wn), .DLL_OFF_N(dn),
        .RD_ADDR(ra), .WR_ADDR(wa), .WR_DATA(d), .BYTE_LANE0_WRITE_N(ln[0]),
        .BYTE_LANE1_WRITE_N(ln[1]), .BYTE_LANE2_WRITE_N(ln[2]), .BYTE_LANE3_WRITE_N(ln[3]),
        .RD_DATA(q), .RD_DATA_OE_N(oe_n), .READ_VALID_FLAG(flag), .TRUE_EDGE(te),
        .WR_READY(wrdy));
    // x18 build on the same pins: upper lanes must never be written
    burst2_ddr_sram_cmd_timing #(.ORG_X36(1'b0), .MEM_ADDR_W(6), .FIFO_DEPTH(8)) DUT_X18 (
        .REF_CLK(clk), .SRST(rst), .READ_SEL_N(rn), .WRITE_SEL_N(wn), .DLL_OFF_N(dn),
        .RD_ADDR(ra), .WR_ADDR(wa), .WR_DATA(d), .BYTE_LANE0_WRITE_N(ln[0]),
        .BYTE_LANE1_WRITE_N(ln[1]), .BYTE_LANE2_WRITE_N(ln[2]), .BYTE_LANE3_WRITE_N(ln[3]),
        .RD_DATA(q18), .RD_DATA_OE_N(), .READ_VALID_FLAG(), .TRUE_EDGE(),
        .WR_READY());
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ====================
    // helpers
    function automatic logic [35:0] rnd();
        return 36'({$urandom, $urandom});
    endfunction
    task automatic chk(input string nm, input logic [35:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic void put(input int x, input logic [35:0] v, input logic [3:0] l);
        for (int k = 0; k < 4; k++) begin
            if (!l[k]) begin
                mem[x & 63][k*9 +: 9] = v[k*9 +: 9];
            end
            if (!l[k] && k < 2) begin
                mem18[x & 63][k*9 +: 9] = v[k*9 +: 9];
            end
        end
    endfunction
    task automatic wr(input int x, input logic [35:0] d0, d1, input logic [3:0] l0, l1,
        input bit keep);
        P.cmd(1'b1, 1'b0, 21'h0, 21'(x), d0, d1, l0, l1);
        if (keep) begin
            put(x, d0, l0);
            put(x + 1, d1, l1);
        end
    endtask
    // w low also asks a write that must be dropped
    task automatic rd(input int x, input logic w, output int n);
        P.cmd(1'b0, w, 21'(x), 21'(x + 8), rnd(), rnd(), 4'h0, 4'h0);
        n = 0;
        while (flag !== 1'b1) begin
            P.rest();
            n++;
            if (n > 20) begin
                n_fail++;
                finish_test();
            end
        end
        P.rest();
        chk("oe_on", 36'h0, {35'h0, oe_n});
        chk("beat1", mem[x & 63], q);
        chk("beat1_x18", mem18[x & 63], q18);
        P.rest();
        chk("beat2", mem[(x + 1) & 63], q);
        chk("beat2_x18", mem18[(x + 1) & 63], q18);
        P.rest();
        chk("oe_off", 36'h1, {35'h0, oe_n});
    endtask
    // ====================
    // sequence
    initial begin
        rst = 1'b1;
        dn = 1'b1;
        n_fail = 0;
        n_tests = 0;
        void'($urandom(32'h3A3E));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 64; i += 2) begin
            wr(i, rnd(), rnd(), 4'h0, 4'h0, 1'b1);
            repeat (2) P.rest();
        end
        for (int i = 0; i < 16; i++) begin
            a = $urandom_range(0, 63);
            wr(a, rnd(), rnd(), i == 0 ? 4'hF : 4'($urandom), 4'($urandom), 1'b1);
            rd(a, 1'b1, lat);
        end
        rd(5, 1'b1, n0);
        dn = 1'b0;
        repeat (8) P.rest();
        rd(6, 1'b1, lat);
        chk("latency", 36'h3, 36'(n0 - lat));
        dn = 1'b1;
        repeat (8) P.rest();
        // a read at the very next true edge must leave no flag of its own
        P.cmd(1'b0, 1'b1, 21'h14, 21'h0, rnd(), rnd(), 4'hF, 4'hF);
        P.cmd(1'b0, 1'b1, 21'h2A, 21'h0, rnd(), rnd(), 4'hF, 4'hF);
        for (int k = 0; k < 8; k++) begin
            P.rest();
            chk("no_flag", 36'(k == 2), {35'h0, flag});
        end
        P.cmd(1'b0, 1'b1, 21'h14, 21'h0, rnd(), rnd(), 4'hF, 4'hF);
        rd(20, 1'b1, lat);
        repeat (6) begin
            P.rest();
            chk("no_flag", 36'h0, {35'h0, flag});
        end
        wr(30, rnd(), rnd(), 4'h0, 4'h0, 1'b1);
        wr(40, rnd(), rnd(), 4'h0, 4'h0, 1'b0);
        rd(40, 1'b1, lat);
        repeat (4) P.rest();
        rd(50, 1'b0, lat);
        rd(58, 1'b1, lat);
        P.cmd(1'b1, 1'b1, 21'h0, 21'h2C, rnd(), rnd(), 4'h0, 4'h0);
        rd(44, 1'b1, lat);
        chk("ready", 36'h1, {35'h0, wrdy});
        finish_test();
    end
endmodule
